// ### logic/scrm_serial_port.sv
`timescale 1ns/100ps
// ****************************************************************
// Three-wire serial frame engine
// ****************************************************************
module scrm_serial_port (
  // Clock and reset
  input  wire logic                         mclk_i,
  input  wire logic                         rst_n_i,
  // Serial pins
  input  wire logic                         sclk_i,
  input  wire logic                         port_select_n_i,
  input  wire logic                         sdio_i,
  output logic                              sdio_o,
  output logic                              sdio_oe_o,
  // Register side
  input  wire logic                         lsb_first_i,
  input  wire logic [scrm_pkg::DATA_W-1:0]  rd_data_i,
  output logic      [scrm_pkg::ADDR_W-1:0]  rd_addr_o,
  output logic      [scrm_pkg::ADDR_W-1:0]  wr_addr_o,
  output logic      [scrm_pkg::DATA_W-1:0]  wr_data_o,
  output logic                              wr_o
);
  import scrm_pkg::*;

  typedef enum logic [2:0] {
    SP_INSTR = 3'h1,
    SP_DATA  = 3'h2,
    SP_HOLD  = 3'h4
  } scrm_sp_state_t;

  scrm_sp_state_t      state_ff, nxt_state;
  logic                sclk_prev_ff, nxt_sclk_prev;
  logic [3:0]          cnt_ff, nxt_cnt;
  logic [15:0]         shift_ff, nxt_shift;
  logic [ADDR_W-1:0]   addr_ff, nxt_addr;
  logic [ADDR_W-1:0]   waddr_ff, nxt_waddr;
  logic [DATA_W-1:0]   wdata_ff, nxt_wdata;
  logic [DATA_W-1:0]   tx_ff, nxt_tx;
  logic [1:0]          left_ff, nxt_left;
  logic                stream_ff, nxt_stream;
  logic                rd_ff, nxt_rd;
  logic                load_ff, nxt_load;
  logic                wr_ff, nxt_wr;
  logic                sdo_ff, nxt_sdo;
  logic                oe_ff, nxt_oe;

  // Next-state logic; pins are sampled on mclk, so sclk must be slow
  always_comb begin
    logic rise;
    logic fall;
    logic [15:0] sh;
    rise        = sclk_i & ~sclk_prev_ff;
    fall        = ~sclk_i & sclk_prev_ff;
    sh          = lsb_first_i ? {sdio_i, shift_ff[15:1]} : {shift_ff[14:0], sdio_i}; // [R10]
    nxt_state   = state_ff;
    nxt_sclk_prev = sclk_i;
    nxt_cnt     = cnt_ff;
    nxt_shift   = shift_ff;
    nxt_addr    = addr_ff;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_tx      = tx_ff;
    nxt_left    = left_ff;
    nxt_stream  = stream_ff;
    nxt_rd      = rd_ff;
    nxt_load    = 1'b0;
    nxt_wr      = 1'b0;
    nxt_sdo     = sdo_ff;
    nxt_oe      = oe_ff;
    if (port_select_n_i) begin
      // Frame ends whenever select rises
      nxt_state = SP_INSTR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        SP_INSTR: begin
          if (rise) begin
            nxt_shift = sh;
            nxt_cnt   = cnt_ff + 4'h1;
            if (cnt_ff == INSTR_LAST) begin
              nxt_addr   = sh[ADDR_W-1:0];
              nxt_rd     = sh[INSTR_RW_BIT];
              nxt_left   = sh[INSTR_WHI_BIT:INSTR_WLO_BIT];
              nxt_stream = (sh[INSTR_WHI_BIT:INSTR_WLO_BIT] == LEN_STREAM);
              nxt_load   = sh[INSTR_RW_BIT];
              nxt_cnt    = 4'h0;
              nxt_state  = SP_DATA;
            end
          end
        end
        SP_DATA: begin
          if (load_ff) begin
            nxt_tx = rd_data_i;
          end
          if (fall && rd_ff) begin
            nxt_sdo = lsb_first_i ? tx_ff[0] : tx_ff[DATA_W-1];
            nxt_oe  = 1'b1;
            nxt_tx  = lsb_first_i ? {1'b0, tx_ff[DATA_W-1:1]} : {tx_ff[DATA_W-2:0], 1'b0};
          end
          if (rise) begin
            nxt_shift = sh;
            nxt_cnt   = cnt_ff + 4'h1;
            if (cnt_ff == BYTE_LAST) begin
              nxt_cnt   = 4'h0;
              nxt_wr    = ~rd_ff;
              nxt_waddr = addr_ff;
              nxt_wdata = lsb_first_i ? sh[15:8] : sh[7:0];
              // Multibyte frames walk down in MSB order, up in LSB order
              nxt_addr  = lsb_first_i ? addr_ff + 13'h0001 : addr_ff - 13'h0001;
              if (!stream_ff && left_ff == 2'h0) begin
                nxt_state = SP_HOLD;
                nxt_oe    = 1'b0;
              end else begin
                nxt_left = stream_ff ? left_ff : left_ff - 2'h1;
                nxt_load = rd_ff;
              end
            end
          end
        end
        SP_HOLD: begin
          nxt_oe = 1'b0;
        end
        default: begin
          nxt_state = SP_INSTR;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff     <= SP_INSTR;
      sclk_prev_ff <= 1'b0;
      cnt_ff       <= 4'h0;
      shift_ff     <= 16'h0000;
      addr_ff      <= 13'h0000;
      waddr_ff     <= 13'h0000;
      wdata_ff     <= 8'h00;
      tx_ff        <= 8'h00;
      left_ff      <= 2'h0;
      stream_ff    <= 1'b0;
      rd_ff        <= 1'b0;
      load_ff      <= 1'b0;
      wr_ff        <= 1'b0;
      sdo_ff       <= 1'b0;
      oe_ff        <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      sclk_prev_ff <= nxt_sclk_prev;
      cnt_ff       <= nxt_cnt;
      shift_ff     <= nxt_shift;
      addr_ff      <= nxt_addr;
      waddr_ff     <= nxt_waddr;
      wdata_ff     <= nxt_wdata;
      tx_ff        <= nxt_tx;
      left_ff      <= nxt_left;
      stream_ff    <= nxt_stream;
      rd_ff        <= nxt_rd;
      load_ff      <= nxt_load;
      wr_ff        <= nxt_wr;
      sdo_ff       <= nxt_sdo;
      oe_ff        <= nxt_oe;
    end
  end

  assign sdio_o    = sdo_ff;
  assign sdio_oe_o = oe_ff;
  assign rd_addr_o = addr_ff;
  assign wr_addr_o = waddr_ff;
  assign wr_data_o = wdata_ff;
  assign wr_o      = wr_ff;

endmodule

// ### logic/scrm_pkg.sv
// ****************************************************************
// Shared constants of the shadowed configuration register map
// ****************************************************************
package scrm_pkg;

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam int          ADDR_W        = 13;
  localparam int          DATA_W        = 8;
  localparam int          INSTR_BITS    = 16;
  localparam int          INSTR_RW_BIT  = 15;  // 1 = read
  localparam int          INSTR_WHI_BIT = 14;
  localparam int          INSTR_WLO_BIT = 13;
  localparam logic [1:0]  LEN_STREAM    = 2'h3;
  localparam logic [3:0]  INSTR_LAST    = 4'hf;
  localparam logic [3:0]  BYTE_LAST     = 4'h7;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADR_PORT   = 13'h000;
  localparam logic [ADDR_W-1:0] ADR_ID     = 13'h001;
  localparam logic [ADDR_W-1:0] ADR_GRADE  = 13'h002;
  localparam logic [ADDR_W-1:0] ADR_PWR    = 13'h008;
  localparam logic [ADDR_W-1:0] ADR_CLK    = 13'h009;
  localparam logic [ADDR_W-1:0] ADR_PLL    = 13'h00a;
  localparam logic [ADDR_W-1:0] ADR_COMMIT = 13'h0ff;
  localparam logic [ADDR_W-1:0] SHADOW_LO  = 13'h008;
  localparam logic [ADDR_W-1:0] SHADOW_HI  = 13'h078;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int          PORT_LSB_HI   = 6;
  localparam int          PORT_LSB_LO   = 1;
  localparam int          PORT_SRST_HI  = 5;
  localparam int          PORT_SRST_LO  = 2;
  localparam int          GRADE_LSB     = 4;
  localparam int          PWR_PIN_BIT   = 5;
  localparam int          CLK_DCF_BIT   = 0;
  localparam int          PLL_LOCK_BIT  = 7;
  localparam int          COMMIT_BIT    = 0;
  localparam logic [7:0]  PWR_MASK      = 8'h23;
  localparam logic [7:0]  CLK_MASK      = 8'h01;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0]  PORT_RST      = 8'h18;
  localparam logic [7:0]  PWR_RST       = 8'h00;
  localparam logic [7:0]  CLK_RST       = 8'h01;
  localparam logic [7:0]  COMMIT_RST    = 8'h00;
  localparam logic [1:0]  GRADE_80      = 2'h0;
  localparam int          COMMIT_CYCLES = 1;  // Write-to-copy latency

endpackage

// ### logic/scrm_top.sv
`timescale 1ns/100ps
// How it works
// [R1] Writes to the shadowed range go to a staging copy, not to the core.
// [R2] Writing one to the commit register bit zero is the commit command.
// [R3] Commit copies all staged values to the active copy at once.
// [R4] The commit bit clears itself after the copy.
// [R5] Only mapped addresses and bits exist; others read zero, ignore writes.
// [R6] Port setup mirrors bit order and soft reset across nibbles; resets 0x18.
// [R7] Grade register shows a read-only two-bit speed code in bits 5:4.
// [R8] Power bit 5 picks full power-off or low-power hold for the pin.
// [R9] Clock bit 0 enables the duty-cycle fixer; resets to 0x01.
// [R10] Serial data is MSB first until LSB-first order is selected.
// [R11] Host writes zeros to unused bits and skips empty addresses; the bench writes 0xff to 0x005 and to unused power bits.
// [R12] Reset loads all registers with their default values.
// [R13] Commit lands one cycle after the write; reads return staged values.
module scrm_top #(
  parameter logic [7:0] PART_ID     = 8'h5a,  // Arbitrary identity value
  parameter logic [1:0] SPEED_GRADE = scrm_pkg::GRADE_80
) (
  // Clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  // Serial host port
  input  wire logic  sclk_i,
  input  wire logic  port_select_n_i,
  input  wire logic  sdio_i,
  output logic       sdio_o,
  output logic       sdio_oe_o,
  // Core status inputs
  input  wire logic  pdn_pin_i,
  input  wire logic  pll_locked_i,
  // Controls to the core; committed except lsb_first_o
  output logic       full_power_off_o,
  output logic       low_power_hold_o,
  output logic [1:0] power_mode_o,
  output logic       duty_cycle_fixer_o,
  output logic       lsb_first_o
);
  import scrm_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic              lsb_first_ff, nxt_lsb_first;
  logic [7:0]        stage_pwr_ff, nxt_stage_pwr;
  logic [7:0]        stage_clk_ff, nxt_stage_clk;
  logic [7:0]        act_pwr_ff,   nxt_act_pwr;
  logic [7:0]        act_clk_ff,   nxt_act_clk;
  logic              commit_ff,    nxt_commit;
  logic              pll_ff,       nxt_pll;
  logic              off_ff,       nxt_off;
  logic              hold_ff,      nxt_hold;
  logic [1:0]        pmode_ff,     nxt_pmode;
  logic              dcf_ff,       nxt_dcf;

  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_stb;
  logic [DATA_W-1:0] rd_data;

  // ****************************************************************
  // Serial frame engine
  // ****************************************************************
  scrm_serial_port u_port (
    .mclk_i          (mclk_i),
    .rst_n_i         (rst_n_i),
    .sclk_i          (sclk_i),
    .port_select_n_i (port_select_n_i),
    .sdio_i          (sdio_i),
    .sdio_o          (sdio_o),
    .sdio_oe_o       (sdio_oe_o),
    .lsb_first_i     (lsb_first_ff),
    .rd_data_i       (rd_data),
    .rd_addr_o       (rd_addr),
    .wr_addr_o       (wr_addr),
    .wr_data_o       (wr_data),
    .wr_o            (wr_stb)
  );

  // ****************************************************************
  // Read decode
  // ****************************************************************
  // Port setup value with both nibbles mirrored
  function automatic logic [7:0] port_image(input logic lsb);
    logic [7:0] v;
    v               = PORT_RST;
    v[PORT_LSB_HI]  = lsb; // [R6]
    v[PORT_LSB_LO]  = lsb; // [R6]
    return v;
  endfunction

  // Shadowed locations return the staged value, not the active one
  always_comb begin
    rd_data = 8'h00; // [R5]
    if (rd_addr == ADR_PORT) begin
      rd_data = port_image(lsb_first_ff); // [R6]
    end else if (rd_addr == ADR_ID) begin
      rd_data = PART_ID;
    end else if (rd_addr == ADR_GRADE) begin
      rd_data[GRADE_LSB+1:GRADE_LSB] = SPEED_GRADE; // [R7]
    end else if (rd_addr == ADR_PWR) begin
      rd_data = stage_pwr_ff; // [R13]
    end else if (rd_addr == ADR_CLK) begin
      rd_data = stage_clk_ff; // [R13]
    end else if (rd_addr == ADR_PLL) begin
      rd_data[PLL_LOCK_BIT] = pll_ff;
    end else if (rd_addr == ADR_COMMIT) begin
      rd_data[COMMIT_BIT] = commit_ff; // [R4]
    end
  end

  // ****************************************************************
  // Write, commit and soft reset
  // ****************************************************************
  // Soft reset wins over everything; host write to commit wins over self-clear
  always_comb begin
    logic srst;
    logic in_shadow;
    srst          = wr_stb && wr_addr == ADR_PORT &&
                    (wr_data[PORT_SRST_HI] || wr_data[PORT_SRST_LO]); // [R6]
    in_shadow     = wr_addr >= SHADOW_LO && wr_addr <= SHADOW_HI;
    nxt_lsb_first = lsb_first_ff;
    nxt_stage_pwr = stage_pwr_ff;
    nxt_stage_clk = stage_clk_ff;
    nxt_act_pwr   = act_pwr_ff;
    nxt_act_clk   = act_clk_ff;
    nxt_commit    = 1'b0; // [R4]
    if (commit_ff) begin
      // All staged settings reach the core on the same edge
      nxt_act_pwr = stage_pwr_ff; // [R3]
      nxt_act_clk = stage_clk_ff; // [R3]
    end
    if (wr_stb) begin
      if (wr_addr == ADR_PORT) begin
        // Either nibble sets the order, so any shift order lands correctly
        nxt_lsb_first = wr_data[PORT_LSB_HI] | wr_data[PORT_LSB_LO]; // [R10]
      end else if (in_shadow && wr_addr == ADR_PWR) begin
        nxt_stage_pwr = wr_data & PWR_MASK; // [R1]
      end else if (in_shadow && wr_addr == ADR_CLK) begin
        nxt_stage_clk = wr_data & CLK_MASK; // [R1]
      end else if (wr_addr == ADR_COMMIT) begin
        nxt_commit = wr_data[COMMIT_BIT]; // [R2]
      end
    end
    if (srst) begin
      nxt_lsb_first = 1'b0; // [R12]
      nxt_stage_pwr = PWR_RST;
      nxt_stage_clk = CLK_RST;
      nxt_act_pwr   = PWR_RST;
      nxt_act_clk   = CLK_RST;
      nxt_commit    = COMMIT_RST[COMMIT_BIT];
    end
  end

  // Register file storage
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lsb_first_ff <= 1'b0; // [R10]
      stage_pwr_ff <= PWR_RST; // [R12]
      stage_clk_ff <= CLK_RST; // [R9]
      act_pwr_ff   <= PWR_RST; // [R8]
      act_clk_ff   <= CLK_RST; // [R9]
      commit_ff    <= 1'b0;
    end else begin
      lsb_first_ff <= nxt_lsb_first;
      stage_pwr_ff <= nxt_stage_pwr;
      stage_clk_ff <= nxt_stage_clk;
      act_pwr_ff   <= nxt_act_pwr;
      act_clk_ff   <= nxt_act_clk;
      commit_ff    <= nxt_commit;
    end
  end

  // ****************************************************************
  // Core-facing outputs
  // ****************************************************************
  // Pin action follows the committed selection, never the staged one
  always_comb begin
    nxt_pll   = pll_locked_i;
    nxt_off   = pdn_pin_i & ~act_pwr_ff[PWR_PIN_BIT]; // [R8]
    nxt_hold  = pdn_pin_i & act_pwr_ff[PWR_PIN_BIT]; // [R8]
    nxt_pmode = act_pwr_ff[1:0];
    nxt_dcf   = act_clk_ff[CLK_DCF_BIT]; // [R9]
  end

  // Output flops; one cycle behind the active copy
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pll_ff   <= 1'b0;
      off_ff   <= 1'b0;
      hold_ff  <= 1'b0;
      pmode_ff <= 2'h0;
      dcf_ff   <= CLK_RST[CLK_DCF_BIT];
    end else begin
      pll_ff   <= nxt_pll;
      off_ff   <= nxt_off;
      hold_ff  <= nxt_hold;
      pmode_ff <= nxt_pmode;
      dcf_ff   <= nxt_dcf;
    end
  end

  assign full_power_off_o   = off_ff;
  assign low_power_hold_o   = hold_ff;
  assign power_mode_o       = pmode_ff;
  assign duty_cycle_fixer_o = dcf_ff;
  assign lsb_first_o        = lsb_first_ff;

endmodule

// ### tb/scrm_top_assertions.sv
`timescale 1ns/100ps
// ********
// Port checks of the register map
// ********
module scrm_top_assertions (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // Serial host port
  input wire logic       sclk_i,
  input wire logic       port_select_n_i,
  input wire logic       sdio_i,
  input wire logic       sdio_o,
  input wire logic       sdio_oe_o,
  // Core side
  input wire logic       pdn_pin_i,
  input wire logic       pll_locked_i,
  input wire logic       full_power_off_o,
  input wire logic       low_power_hold_o,
  input wire logic [1:0] power_mode_o,
  input wire logic       duty_cycle_fixer_o,
  input wire logic       lsb_first_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Serial clock fell one edge ago
  sequence s_sclk_fell;
    $past(sclk_i, 2) && !$past(sclk_i);
  endsequence
  // Port idle long enough for any commit to land
  sequence s_port_idle;
    port_select_n_i [*6];
  endsequence

  // Reset drives the defaults; not disabled by itself
  property p_reset_vals;
    disable iff (1'b0) !rst_n_i |=> !sdio_oe_o && duty_cycle_fixer_o && !lsb_first_o
      && power_mode_o == 2'h0 && !full_power_off_o && !low_power_hold_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset defaults wrong");
  property p_quiet;
    s_port_idle |=> $stable(power_mode_o) && $stable(duty_cycle_fixer_o) && $stable(lsb_first_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("control moved while idle");
  property p_oe_idle;
    port_select_n_i ##1 port_select_n_i |-> !sdio_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("driving while deselected");
  property p_oe_rise;
    $rose(sdio_oe_o) |-> s_sclk_fell;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive began off a fall");
  property p_sdio_step;
    $changed(sdio_o) && sdio_oe_o && $past(sdio_oe_o) |-> s_sclk_fell;
  endproperty
  a_sdio_step: assert property (p_sdio_step) else $error("data moved off a fall");
  property p_pin_off;
    !pdn_pin_i |=> !full_power_off_o && !low_power_hold_o;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("power action without pin");
  property p_pin_on;
    pdn_pin_i |=> full_power_off_o != low_power_hold_o;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin gave no single action");
  property p_excl;
    full_power_off_o |-> !low_power_hold_o;
  endproperty
  a_excl: assert property (p_excl) else $error("both power actions");
endmodule

bind scrm_top scrm_top_assertions i_scrm_top_assertions (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .port_select_n_i(port_select_n_i),
  .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .pdn_pin_i(pdn_pin_i),
  .pll_locked_i(pll_locked_i), .full_power_off_o(full_power_off_o),
  .low_power_hold_o(low_power_hold_o), .power_mode_o(power_mode_o),
  .duty_cycle_fixer_o(duty_cycle_fixer_o), .lsb_first_o(lsb_first_o));

// ### tb/scrm_host_model.sv
`timescale 1ns/100ps
// ********
// Serial host at the far side of the port
// ********
module scrm_host_model (
  // Clock
  input  wire logic mclk_i,
  // Device pin side
  input  wire logic sdio_o,
  input  wire logic sdio_oe_o,
  output logic      sclk_o,
  output logic      port_select_n_o,
  output logic      sdio_wire_o
);
  import scrm_pkg::*;
  logic drv_en;
  logic drv_d;
  logic lsb_mode;
  // Idle pins; clock stands low outside frames
  initial begin
    sclk_o = 1'b0;
    port_select_n_o = 1'b1;
    drv_en = 1'b1;
    drv_d = 1'b0;
    lsb_mode = 1'b0;
  end
  // Released line shows the inverse bit, so a stale value never passes
  assign sdio_wire_o = sdio_oe_o ? sdio_o : (drv_en ? drv_d : ~drv_d);

  // One serial bit, three mclk cycles per phase, sampled before the rise
  task automatic clk_bit(input logic bit_v, input logic drive, output logic seen);
    drv_en = drive;
    if (drive) begin
      drv_d = bit_v;
    end
    repeat (3) @(negedge mclk_i);
    seen = sdio_wire_o;
    sclk_o = 1'b1;
    repeat (3) @(negedge mclk_i);
    sclk_o = 1'b0;
  endtask

  // Frame of len+1 bytes, two at most; byte j travels in wd[8*j +: 8]
  task automatic xfer(input logic rd, input logic [1:0] len, input logic [ADDR_W-1:0] adr,
                      input logic [15:0] wd, output logic [DATA_W-1:0] rv);
    logic [INSTR_BITS-1:0] ins;
    logic                  seen;
    int                    k;
    ins = {rd, len, adr};
    @(negedge mclk_i);
    port_select_n_o = 1'b0;
    for (int i = 0; i < INSTR_BITS; i++) begin
      k = lsb_mode ? i : INSTR_BITS - 1 - i;
      clk_bit(ins[k], 1'b1, seen);
    end
    for (int j = 0; j <= int'(len); j++) begin
      for (int i = 0; i < DATA_W; i++) begin
        k = lsb_mode ? i : DATA_W - 1 - i;
        clk_bit(wd[8 * j + k], !rd, seen);
        rv[k] = seen;
      end
    end
    repeat (3) @(negedge mclk_i);
    port_select_n_o = 1'b1;
    drv_en = 1'b1;
    repeat (2) @(negedge mclk_i);
    // Track the order change; soft reset returns to MSB first
    if (!rd && adr == ADR_PORT) begin
      lsb_mode = (wd[PORT_LSB_HI] | wd[PORT_LSB_LO]) & ~(wd[PORT_SRST_HI] | wd[PORT_SRST_LO]);
    end
  endtask
endmodule

// ### tb/test_scrm_top.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
// ********
// Register map bench
// ********
module test_scrm_top;
  import scrm_pkg::*;
  localparam logic [7:0] TB_ID    = 8'h3c;  // Arbitrary identity value
  localparam logic [1:0] TB_GRADE = 2'h1;
  logic       mclk_i;
  logic       rst_n_i;
  logic       sclk_i;
  logic       port_select_n_i;
  logic       sdio_i;
  logic       sdio_o;
  logic       sdio_oe_o;
  logic       pdn_pin_i;
  logic       pll_locked_i;
  logic       full_power_off_o;
  logic       low_power_hold_o;
  logic [1:0] power_mode_o;
  logic       duty_cycle_fixer_o;
  logic       lsb_first_o;
  logic [7:0] rv;
  int         fails;
  int         samples_checked;

  scrm_top #(.PART_ID(TB_ID), .SPEED_GRADE(TB_GRADE)) i_scrm_top (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .port_select_n_i(port_select_n_i),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .pdn_pin_i(pdn_pin_i),
    .pll_locked_i(pll_locked_i), .full_power_off_o(full_power_off_o),
    .low_power_hold_o(low_power_hold_o), .power_mode_o(power_mode_o),
    .duty_cycle_fixer_o(duty_cycle_fixer_o), .lsb_first_o(lsb_first_o));
  scrm_host_model i_scrm_host_model (
    .mclk_i(mclk_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .sclk_o(sclk_i),
    .port_select_n_o(port_select_n_i), .sdio_wire_o(sdio_i));

  // Register access through the serial host
  task automatic wr(input logic [ADDR_W-1:0] adr, input logic [DATA_W-1:0] d);
    i_scrm_host_model.xfer(1'b0, 2'h0, adr, {8'h00, d}, rv);
  endtask
  // Two bytes; in MSB order the second lands one address down
  task automatic wr2(input logic [ADDR_W-1:0] adr, input logic [15:0] d);
    i_scrm_host_model.xfer(1'b0, 2'h1, adr, d, rv);
  endtask
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] adr,
                        input logic [DATA_W-1:0] exp);
    i_scrm_host_model.xfer(1'b1, 2'h0, adr, 16'h0000, rv);
    `CHK(what, exp, rv)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Clock and watchdog; a full run is about 5000 cycles
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    close_out();
  end

  // Tests
  initial begin
    fails = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    pdn_pin_i = 1'b0;
    pll_locked_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    `CHK("order out", 1'b0, lsb_first_o)
    rd_chk("port", ADR_PORT, 8'h18);
    rd_chk("identity", ADR_ID, TB_ID);
    rd_chk("grade", ADR_GRADE, {2'h0, TB_GRADE, 4'h0});
    rd_chk("power", ADR_PWR, 8'h00);
    rd_chk("clock", ADR_CLK, 8'h01);
    rd_chk("lock", ADR_PLL, 8'h80);
    pll_locked_i = 1'b0;
    rd_chk("unlocked", ADR_PLL, 8'h00);
    rd_chk("commit", ADR_COMMIT, 8'h00);
    // Staged values wait for the commit bit
    pdn_pin_i = 1'b1;
    wr(ADR_PWR, 8'h22);
    wr(ADR_CLK, 8'h00);
    rd_chk("staged", ADR_PWR, 8'h22);
    wr(ADR_COMMIT, 8'h00);
    `CHK("mode held", 2'h0, power_mode_o)
    `CHK("fixer held", 1'b1, duty_cycle_fixer_o)
    `CHK("off pin", 1'b1, full_power_off_o)
    wr(ADR_COMMIT, 8'h01);
    `CHK("mode moved", 2'h2, power_mode_o)
    `CHK("fixer moved", 1'b0, duty_cycle_fixer_o)
    `CHK("hold pin", 1'b1, low_power_hold_o)
    rd_chk("commit clear", ADR_COMMIT, 8'h00);
    // Unmapped, read-only and unused bits ignore writes
    wr(13'h005, 8'hff);
    rd_chk("unmapped", 13'h005, 8'h00);
    wr(ADR_GRADE, 8'h20);
    rd_chk("grade ro", ADR_GRADE, {2'h0, TB_GRADE, 4'h0});
    wr(ADR_PWR, 8'hff);
    rd_chk("power mask", ADR_PWR, PWR_MASK);
    // Two-byte frame steps the address down in MSB order
    wr2(ADR_CLK, {8'h21, 8'h01});
    rd_chk("pair second", ADR_PWR, 8'h21);
    rd_chk("pair first", ADR_CLK, 8'h01);
    // Bit order, then soft reset sent in LSB-first order
    pdn_pin_i = 1'b0;
    wr(ADR_PORT, 8'h5a);
    `CHK("lsb out", 1'b1, lsb_first_o)
    rd_chk("port lsb", ADR_PORT, 8'h5a);
    wr(ADR_PORT, 8'h7e);
    `CHK("order reset", 1'b0, lsb_first_o)
    `CHK("fixer reset", 1'b1, duty_cycle_fixer_o)
    rd_chk("port reset", ADR_PORT, PORT_RST);
    rd_chk("power reset", ADR_PWR, PWR_RST);
    // Hard reset in mid-run restores active controls
    wr(ADR_CLK, 8'h00);
    wr(ADR_COMMIT, 8'h01);
    `CHK("fixer off", 1'b0, duty_cycle_fixer_o)
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    `CHK("fixer hard", 1'b1, duty_cycle_fixer_o)
    rd_chk("clock hard", ADR_CLK, CLK_RST);
    close_out();
  end
endmodule
